// ===== logic/sclkg_top.sv
// Top module of the system clock generation unit
`timescale 1ns/1ns
module sclkg_top
   import sclkg_pkg::*;
#(
   parameter int FIX_CYC = SCLKG_FIX_CYC
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   input  wire logic        POR_N,
   input  wire sclkg_src_t  SRC_SEL,
   input  wire logic        RTC_ON_XTAL,
   input  wire sclkg_osc_t  OSC_IN,
   input  wire logic        PORT_OUT_VAL,
   input  wire logic        PORT_OUT_EN,
   output logic             CPU_CORE_CLK,
   output logic             PERIPH_CLK,
   output logic             CLK_RUN,
   output logic             CRYSTAL_OUT_PIN_O,
   output logic             CRYSTAL_OUT_PIN_OE,
   output logic [5:0]       RC_TRIM,
   output logic             LOW_POWER_CLOCK_SELECT,
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY
);

   // Register map, one aligned word each:
   //   0x00 control: bit 0 requests power-down
   //   0x04 divider: CPU clock is source over setting plus one
   //   0x08 trim: bits 5:0 trim code, bit 6 clock out enable
   //   0x0c auxiliary: bit 7 low power clock select
   //   0x10 status: bit 0 running, bits 5:4 wake-up phase
   // Unmapped words read zero and answer with a slave error; writes
   // to them are dropped.
   // All clocks leave as registered levels on the core clock: the CPU
   // clock, the peripheral clock at half its rate and the optional
   // clock out on the crystal output pin.

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // True for any of the three crystal settings
   // Used by the wake-up count and by the pin ownership logic
   function automatic logic is_xtal(input sclkg_src_t s);
      is_xtal = (s == SCLKG_SRC_XTAL_LOW) || (s == SCLKG_SRC_XTAL_MED) ||
                (s == SCLKG_SRC_XTAL_HIGH);
   endfunction

   // Known register offset
   // Shared by the read and the write decoder
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == SCLKG_CTRL_OFS) || (a == SCLKG_DIV_OFS) ||
               (a == SCLKG_TRIM_OFS) || (a == SCLKG_AUX_OFS) ||
               (a == SCLKG_STAT_OFS);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   // Everything but the trim field lives in one registered struct;
   // the trim field has its own register because only a power-on
   // reset may load it
   sclkg_state_t s_q;         // Registered state
   sclkg_state_t s_d;         // Next state
   logic [5:0]   trim_q;      // Trim field, power-on reset only
   logic [5:0]   trim_d;      // Next trim
   logic         src_raw;     // Selected oscillator level
   logic         src_rise;    // Source clock rising edge
   logic         aw_go;       // Write address taken
   logic         w_go;        // Write data taken
   logic         ar_go;       // Read address taken
   logic         do_wr;       // Write commits this cycle
   logic [31:0]  wval;        // Write value
   logic [7:0]   waddr;       // Write address

   ////////////////////////////////////////////////////////////////////////////
   // Source selection; sources are sampled as synchronous levels

   // Pick one of four oscillators from configuration
   always_comb begin
      case (SRC_SEL)
         SCLKG_SRC_WDOG:      src_raw = OSC_IN.wdog;
         SCLKG_SRC_RC:        src_raw = OSC_IN.rc;
         SCLKG_SRC_XTAL_LOW,
         SCLKG_SRC_XTAL_MED,
         SCLKG_SRC_XTAL_HIGH: src_raw = OSC_IN.xtal;
         SCLKG_SRC_EXT:       src_raw = OSC_IN.ext;
         // Codes 6 and 7 are unused and fall back to the RC source
         default:             src_raw = OSC_IN.rc;
      endcase
   end

   // Edge only when source moves, so a stopped input freezes the wake-up edge count and the divider
   assign src_rise = src_raw && !s_q.src_q;

   // Bus handshakes: a channel is taken when valid meets ready; the
   // write commits once address and data are both present and no
   // response is still waiting for the master
   assign aw_go = AWVALID && !s_q.awv && !s_q.bvalid;
   assign w_go  = WVALID && !s_q.wv && !s_q.bvalid;
   assign ar_go = ARVALID && !s_q.rvalid;
   assign do_wr = (s_q.awv || aw_go) && (s_q.wv || w_go) && !s_q.bvalid;
   assign wval  = s_q.wv ? s_q.wd : WDATA;
   assign waddr = s_q.awv ? s_q.awa : AWADDR;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      // Hold everything by default and track the source level
      s_d = s_q;
      trim_d = trim_q;
      s_d.src_q = src_raw;
      s_d.tick = 1'b0;

      // Wake-up: after any reset and on leaving power-down, count
      // source rising edges, then a fixed number of core cycles, and
      // only then let the CPU clock run; crystals get the longer count
      // because they take longer to settle
      // Wake-up sequencer
      case (s_q.wst)
         // Count source edges; a stopped source holds the count
         SCLKG_W_COUNT: begin
            if (src_rise) begin
               if (s_q.wcnt == (is_xtal(SRC_SEL) ? SCLKG_WAKE_XTAL - 10'd1
                                : SCLKG_WAKE_OTHER - 10'd1)) begin
                  s_d.wst = SCLKG_W_FIXED;
                  s_d.fcnt = 16'h0000;
               end else begin
                  s_d.wcnt = s_q.wcnt + 10'd1;
               end
            end
         end

         // Fixed settling interval in core cycles
         SCLKG_W_FIXED: begin
            if (s_q.fcnt == 16'(FIX_CYC - 1)) begin
               s_d.wst = SCLKG_W_RUN;
            end else begin
               s_d.fcnt = s_q.fcnt + 16'h0001;
            end
         end

         // Running until software asks for power-down
         SCLKG_W_RUN: begin
            if (s_q.pd) begin
               s_d.wst = SCLKG_W_DOWN;   // Enter power-down
            end
         end

         // Clocks stopped until the request is withdrawn
         SCLKG_W_DOWN: begin
            if (!s_q.pd) begin
               s_d.wst = SCLKG_W_COUNT;  // Exit restarts delay
               s_d.wcnt = 10'h000;
            end
         end
         // Unreachable codes go back to edge counting; the edge count keeps its value
         default: s_d.wst = SCLKG_W_COUNT;
      endcase
      s_d.cpu_en = (s_d.wst == SCLKG_W_RUN);

      // The tick is the CPU clock edge; it also paces the peripheral
      // clock and the machine-cycle phase
      // Divider: tick every div+1 source edges
      if (s_q.cpu_en && src_rise) begin
         // Compare with >= so a setting lowered below the running count
         // ends the period at the next edge instead of wrapping round
         if (s_q.dcnt >= s_q.div) begin   // Acts at once
            s_d.dcnt = 8'h00;
            s_d.tick = 1'b1;
         end else begin
            // Count this edge toward the next tick
            s_d.dcnt = s_q.dcnt + 8'h01;
         end
      end

      // CPU clock: undivided follows source, else pulse per tick
      if (!s_q.cpu_en) begin
         s_d.cpu_core_clock = 1'b0;                // Gated until wake-up is done
      end else if (s_q.div == 8'h00) begin
         // Setting zero: the source itself, one core cycle late
         s_d.cpu_core_clock = src_raw;
      end else begin
         // Otherwise one core-cycle pulse per tick, evenly spaced
         s_d.cpu_core_clock = s_d.tick;
      end

      // Peripheral clock at half the CPU clock
      if (s_d.tick) begin
         s_d.pclk = !s_q.pclk;   // Also the machine-cycle phase
      end
      // Held low while gated, so it restarts in a known phase
      if (!s_q.cpu_en) begin
         s_d.pclk = 1'b0;
      end

      // Pin drive: clock out only if crystal unused
      // The real-time clock's crystal needs the pin as well, so while
      // it runs the pin is neither clock out nor an ordinary port pin
      if (!is_xtal(SRC_SEL) && !RTC_ON_XTAL && s_q.clock_out_enable) begin
         s_d.cout = s_d.pclk;            // Half CPU rate
         s_d.cout_oe = 1'b1;
      end else if (!RTC_ON_XTAL && (SRC_SEL == SCLKG_SRC_EXT ||
                   SRC_SEL == SCLKG_SRC_RC ||
                   SRC_SEL == SCLKG_SRC_WDOG)) begin
         s_d.cout = PORT_OUT_VAL;        // Ordinary port pin
         s_d.cout_oe = PORT_OUT_EN;
      end else begin
         s_d.cout = 1'b0;                // Crystal owns the pin
         s_d.cout_oe = 1'b0;
      end

      // Write channel capture; address and data may arrive in either
      // order and each waits here for its partner
      if (aw_go) begin
         s_d.awv = 1'b1;
         s_d.awa = AWADDR;
      end
      if (w_go) begin
         s_d.wv = 1'b1;
         s_d.wd = WDATA;
      end
      // Commit once both halves are present; the response stands
      // until the master takes it
      if (do_wr) begin
         s_d.awv = 1'b0;
         s_d.wv = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = mapped(waddr) ? SCLKG_RESP_OK : SCLKG_RESP_ERR;
         // Register bits all sit in the lowest byte lane
         if (WSTRB[0] || s_q.wv) begin
            case (waddr)
               SCLKG_CTRL_OFS: s_d.pd = wval[SCLKG_CTRL_PD_BIT];
               SCLKG_DIV_OFS:  s_d.div = wval[7:0];
               // Trim code and clock out enable share one word
               SCLKG_TRIM_OFS: begin
                  trim_d = wval[5:0];
                  s_d.clock_out_enable = wval[SCLKG_TRIM_CLOCK_OUT_ENABLE_BIT];
               end
               SCLKG_AUX_OFS:  s_d.lp = wval[SCLKG_AUX_LP_BIT];
               default: ;
            endcase
         end
      end else if (s_q.bvalid && BREADY) begin
         // Response taken by the master
         s_d.bvalid = 1'b0;
      end

      // Read channel; a read has no side effect, and its data stands
      // until the master takes it
      if (ar_go) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = mapped(ARADDR) ? SCLKG_RESP_OK : SCLKG_RESP_ERR;
         case (ARADDR)
            SCLKG_CTRL_OFS: s_d.rdata = {31'h0, s_q.pd};
            SCLKG_DIV_OFS:  s_d.rdata = {24'h0, s_q.div};
            SCLKG_TRIM_OFS: s_d.rdata = {25'h0, s_q.clock_out_enable, trim_q};
            SCLKG_AUX_OFS:  s_d.rdata = {24'h0, s_q.lp, 7'h00};
            // Status shows the wake-up phase for software to poll
            SCLKG_STAT_OFS: s_d.rdata = {26'h0, s_q.wst, 3'h0,
                                         s_q.cpu_en};
            default:        s_d.rdata = 32'h0000_0000;
         endcase
      end else if (s_q.rvalid && RREADY) begin
         s_d.rvalid = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   // Main state; every reset clears low power select
   // Any reset also gates the clocks and restarts the wake-up count
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         // Divider setting, bus flags and pin drive all start clear
         s_q <= '0;
         s_q.wst <= SCLKG_W_COUNT;
         s_q.div <= SCLKG_DIV_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Trim survives all but power-on reset
   // Watchdog, software and external resets leave the trim alone
   always_ff @(posedge CORE_CLK or negedge POR_N) begin
      if (!POR_N) begin
         trim_q <= SCLKG_TRIM_FACTORY;
      end else begin
         trim_q <= trim_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops

   assign CPU_CORE_CLK           = s_q.cpu_core_clock;
   assign PERIPH_CLK             = s_q.pclk;
   assign CLK_RUN                = s_q.cpu_en;
   assign CRYSTAL_OUT_PIN_O      = s_q.cout;
   assign CRYSTAL_OUT_PIN_OE     = s_q.cout_oe;
   assign RC_TRIM                = trim_q;
   assign LOW_POWER_CLOCK_SELECT = s_q.lp;
   // Ready is refused while a half is held or a response is pending
   assign AWREADY                = !s_q.awv && !s_q.bvalid;
   assign WREADY                 = !s_q.wv && !s_q.bvalid;
   assign BVALID                 = s_q.bvalid;
   assign BRESP                  = s_q.bresp;
   assign ARREADY                = !s_q.rvalid;
   assign RVALID                 = s_q.rvalid;
   assign RDATA                  = s_q.rdata;
   assign RRESP                  = s_q.rresp;

endmodule

// ===== logic/sclkg_pkg.sv
// Package of constants and types for the system clock generation unit
// What this block does
// - Source clock picked from four flash-configured oscillators
// - Crystal has low, medium and high speed settings
// - External clock input works from stopped to 12 MHz
// - External clock mode frees crystal out pin
// - CPU clock divides source by up to 256
// - Divider rewrite takes effect without stalling execution
// - Machine cycle equals two CPU clock cycles
// - Peripheral clock runs at half CPU clock
// - Crystal sources wait 992 cycles plus fixed delay
// - Other sources wait 224 cycles plus fixed delay
// - Clock out only when crystal is unused
// - Clock out driven only while enable bit set
// - Clock out toggles at half CPU clock
// - Six-bit trim field, factory value, software writable
// - Low power select clears on reset, set if slow
// - Only power-on reset reloads the trim field
package sclkg_pkg;

   // Register byte offsets
   localparam logic [7:0] SCLKG_CTRL_OFS   = 8'h00;
   localparam logic [7:0] SCLKG_DIV_OFS    = 8'h04;
   localparam logic [7:0] SCLKG_TRIM_OFS   = 8'h08;
   localparam logic [7:0] SCLKG_AUX_OFS    = 8'h0c;
   localparam logic [7:0] SCLKG_STAT_OFS   = 8'h10;

   // Field positions
   localparam int SCLKG_TRIM_CLOCK_OUT_ENABLE_BIT = 6;
   localparam int SCLKG_AUX_LP_BIT     = 7;
   localparam int SCLKG_CTRL_PD_BIT    = 0;

   // Reset values
   localparam logic [7:0] SCLKG_DIV_RST = 8'h00;
   localparam logic [5:0] SCLKG_TRIM_FACTORY = 6'h20;  // Arbitrary value

   // Wake-up counts in source clock cycles
   localparam logic [9:0] SCLKG_WAKE_XTAL = 10'h3e0;
   localparam logic [9:0] SCLKG_WAKE_OTHER = 10'h0e0;

   // Fixed wake-up interval, least time, in ns, and its cycle count
   localparam int SCLKG_FIX_NS     = 60000;
   localparam int SCLKG_CLK_NS     = 4;
   localparam int SCLKG_FIX_CYC    = (SCLKG_FIX_NS + SCLKG_CLK_NS - 1)
                                     / SCLKG_CLK_NS;

   // AXI responses
   localparam logic [1:0] SCLKG_RESP_OK  = 2'b00;
   localparam logic [1:0] SCLKG_RESP_ERR = 2'b10;

   // Source selection from flash configuration
   typedef enum logic [2:0] {
      SCLKG_SRC_WDOG,
      SCLKG_SRC_RC,
      SCLKG_SRC_XTAL_LOW,
      SCLKG_SRC_XTAL_MED,
      SCLKG_SRC_XTAL_HIGH,
      SCLKG_SRC_EXT
   } sclkg_src_t;

   // Wake-up sequencer states
   typedef enum logic [1:0] {
      SCLKG_W_COUNT,
      SCLKG_W_FIXED,
      SCLKG_W_RUN,
      SCLKG_W_DOWN
   } sclkg_wst_t;

   // Raw oscillator inputs travelling together
   typedef struct packed {
      logic wdog;
      logic rc;
      logic xtal;
      logic ext;
   } sclkg_osc_t;

   // Full state of the block
   typedef struct packed {
      sclkg_wst_t  wst;
      logic [9:0]  wcnt;
      logic [15:0] fcnt;
      logic [7:0]  div;
      logic [7:0]  dcnt;
      logic        src_q;
      logic        tick;
      logic        cpu_en;
      logic        cpu_core_clock;
      logic        pclk;
      logic        cout;
      logic        cout_oe;
      logic [5:0]  trim;
      logic        clock_out_enable;
      logic        lp;
      logic        pd;
      logic        awv;
      logic [7:0]  awa;
      logic        wv;
      logic [31:0] wd;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } sclkg_state_t;

endpackage

// ===== tb/sclkg_checker.sv
// Checker of gating, clock pin and bus answers of the clock unit
`timescale 1ns/1ns
module sclkg_checker
   import sclkg_pkg::*;
(
   input wire logic        CORE_CLK,
   input wire logic        RST_N,
   input wire sclkg_src_t  SRC_SEL,
   input wire logic        RTC_ON_XTAL,
   input wire logic        CPU_CORE_CLK,
   input wire logic        PERIPH_CLK,
   input wire logic        CLK_RUN,
   input wire logic        CRYSTAL_OUT_PIN_OE,
   input wire logic        LOW_POWER_CLOCK_SELECT,
   input wire logic        AWVALID,
   input wire logic        AWREADY,
   input wire logic        WVALID,
   input wire logic        WREADY,
   input wire logic [1:0]  BRESP,
   input wire logic        BVALID,
   input wire logic        BREADY,
   input wire logic        ARVALID,
   input wire logic        ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic        RVALID,
   input wire logic        RREADY
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // Both write halves taken at one edge
   sequence s_wr_taken;
      AWVALID && AWREADY && WVALID && WREADY;
   endsequence
   sequence s_rd_taken;
      ARVALID && ARREADY;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   chk_rtc_blocks: assert property (RTC_ON_XTAL |=>
      !CRYSTAL_OUT_PIN_OE) else $error("pin driven while rtc on crystal");
   chk_xtal_blocks: assert property ((SRC_SEL inside
      {SCLKG_SRC_XTAL_LOW, SCLKG_SRC_XTAL_MED, SCLKG_SRC_XTAL_HIGH})
      |=> !CRYSTAL_OUT_PIN_OE) else $error("pin driven on crystal source");
   chk_gate_cpu: assert property ((!CLK_RUN)[*3] |->
      !CPU_CORE_CLK && !PERIPH_CLK) else $error("clocks run while gated");
   chk_wake_min: assert property ($rose(RST_N) |->
      (!CLK_RUN)[*8]) else $error("clock released too early");
   chk_lp_clear: assert property ($rose(RST_N) |->
      !LOW_POWER_CLOCK_SELECT) else $error("low power bit kept");
   chk_b_answer: assert property (s_wr_taken |=> BVALID)
      else $error("no write response");
   chk_r_answer: assert property (s_rd_taken |=> RVALID)
      else $error("no read response");
   chk_b_hold: assert property (BVALID && !BREADY |=>
      BVALID && $stable(BRESP)) else $error("write response dropped");
   chk_r_hold: assert property (RVALID && !RREADY |=>
      RVALID && $stable(RDATA)) else $error("read response dropped");
endmodule
bind sclkg_top sclkg_checker i_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .SRC_SEL(SRC_SEL), .RTC_ON_XTAL(RTC_ON_XTAL),
   .CPU_CORE_CLK(CPU_CORE_CLK), .PERIPH_CLK(PERIPH_CLK), .CLK_RUN(CLK_RUN),
   .CRYSTAL_OUT_PIN_OE(CRYSTAL_OUT_PIN_OE),
   .LOW_POWER_CLOCK_SELECT(LOW_POWER_CLOCK_SELECT), .AWVALID(AWVALID),
   .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
   .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
   .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY));

// ===== tb/tb_top.sv
// Self-checking bench of the clock generation unit
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
   mismatches++; $display("wrong value %s exp %h got %h", nm, ex, got); \
   end end
module tb_top
   import sclkg_pkg::*;
;
   logic CORE_CLK = 0, RST_N = 0, POR_N = 0, RTC_ON_XTAL = 0;
   logic PORT_OUT_EN = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
   logic PORT_OUT_VAL = 1;
   logic ARVALID = 0, RREADY = 0;
   sclkg_src_t SRC_SEL = SCLKG_SRC_RC;
   sclkg_osc_t OSC_IN = '0;
   logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
   logic [31:0] WDATA = 32'h0, RDATA, q;
   logic CPU_CORE_CLK, PERIPH_CLK, CLK_RUN, CRYSTAL_OUT_PIN_O;
   logic CRYSTAL_OUT_PIN_OE, LOW_POWER_CLOCK_SELECT, AWREADY, WREADY;
   logic BVALID, ARREADY, RVALID;
   logic [5:0] RC_TRIM;
   logic [1:0] BRESP, RRESP, r;
   int mismatches = 0, n_compared = 0, c, nc, np, no, s, lo;
   sclkg_top #(.FIX_CYC(4)) i_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
      .POR_N(POR_N), .SRC_SEL(SRC_SEL), .RTC_ON_XTAL(RTC_ON_XTAL),
      .OSC_IN(OSC_IN), .PORT_OUT_VAL(PORT_OUT_VAL),
      .PORT_OUT_EN(PORT_OUT_EN),
      .CPU_CORE_CLK(CPU_CORE_CLK), .PERIPH_CLK(PERIPH_CLK),
      .CLK_RUN(CLK_RUN), .CRYSTAL_OUT_PIN_O(CRYSTAL_OUT_PIN_O),
      .CRYSTAL_OUT_PIN_OE(CRYSTAL_OUT_PIN_OE), .RC_TRIM(RC_TRIM),
      .LOW_POWER_CLOCK_SELECT(LOW_POWER_CLOCK_SELECT), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf),
      .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY));
   // Core clock and all four oscillators at half its rate
   always #2 CORE_CLK = ~CORE_CLK;
   always @(posedge CORE_CLK) OSC_IN <= ~OSC_IN;
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Reset pulse; por also reloads the trim field
   task automatic rst(input logic por);
      @(posedge CORE_CLK);
      RST_N <= 1'b0;
      POR_N <= ~por;
      repeat (6) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      POR_N <= 1'b1;
      @(negedge CORE_CLK);
   endtask
   // One bus transfer; ready comes late so the slave must hold
   task automatic acc(input logic wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] qd, output logic [1:0] rs);
      int n;
      logic ta, tw, tb;
      @(posedge CORE_CLK);
      AWADDR <= a;
      ARADDR <= a;
      WDATA <= d;
      AWVALID <= wr;
      WVALID <= wr;
      ARVALID <= ~wr;
      for (n = 0; n < 40; n++) begin
         @(negedge CORE_CLK);
         ta = AWVALID && AWREADY || ARVALID && ARREADY;
         tw = WVALID && WREADY;
         tb = BVALID && BREADY || RVALID && RREADY;
         qd = RDATA;
         rs = wr ? BRESP : RRESP;
         if (tb) return;
         @(posedge CORE_CLK);
         if (ta) AWVALID <= 1'b0;
         if (ta) ARVALID <= 1'b0;
         if (tw) WVALID <= 1'b0;
         if (n == 1) BREADY <= wr;
         if (n == 1) RREADY <= ~wr;
      end
      mismatches++;
      tally_and_finish();
   endtask
   // Read and compare; ready released at the next edge
   task automatic rdc(input string nm, input logic [7:0] a,
         input logic [31:0] ex);
      logic [31:0] qd;
      acc(1'b0, a, 32'h0, qd, r);
      @(posedge CORE_CLK);
      RREADY <= 1'b0;
      `CHK(nm, ex, qd)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d, q, r);
      @(posedge CORE_CLK);
      BREADY <= 1'b0;
      @(negedge CORE_CLK);
   endtask
   task automatic wait_run();
      for (c = 0; c < 3000 && CLK_RUN !== 1'b1; c++) @(negedge CORE_CLK);
      if (c == 3000) mismatches++;
      if (c == 3000) tally_and_finish();
   endtask
   // Count cpu rises and pin toggles over 64 core cycles
   task automatic cnt();
      logic c0, p0, o0;
      nc = 0;
      np = 0;
      no = 0;
      @(negedge CORE_CLK);
      repeat (64) begin
         {c0, p0, o0} = {CPU_CORE_CLK, PERIPH_CLK, CRYSTAL_OUT_PIN_O};
         @(negedge CORE_CLK);
         nc += int'(CPU_CORE_CLK && !c0);
         np += int'(PERIPH_CLK != p0);
         no += int'(CRYSTAL_OUT_PIN_O != o0);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst(1'b1);
      rdc("div", SCLKG_DIV_OFS, 32'h0);
      `CHK("rresp_ok", SCLKG_RESP_OK, r)
      rdc("trim", SCLKG_TRIM_OFS, 32'(SCLKG_TRIM_FACTORY));
      rdc("aux", SCLKG_AUX_OFS, 32'h0);
      rdc("unmapped", 8'h40, 32'h0);
      `CHK("rresp_err", SCLKG_RESP_ERR, r)
      wr(8'h40, 32'hff);
      `CHK("bresp_err", SCLKG_RESP_ERR, r)
      `CHK("trim_pin", SCLKG_TRIM_FACTORY, RC_TRIM)
      $display("test reset done");
      // Wake-up length for every source
      for (s = 0; s < 6; s++) begin
         @(posedge CORE_CLK);
         SRC_SEL <= sclkg_src_t'(s);
         rst(1'b0);
         wait_run();
         lo = 2 * int'(s inside {2, 3, 4} ? SCLKG_WAKE_XTAL
                                           : SCLKG_WAKE_OTHER);
         `CHK("wake", 1'b1, (c >= lo - 8 && c <= lo + 40))
      end
      $display("test wake done");
      cnt();
      `CHK("cpu_div0", 1'b1, (nc inside {[31:33]}))
      `CHK("pclk", 1'b1, (np inside {[nc-1:nc+1]}))
      wr(SCLKG_DIV_OFS, 32'h3);
      `CHK("bresp_ok", SCLKG_RESP_OK, r)
      cnt();
      `CHK("cpu_div4", 1'b1, (nc inside {[7:9]}))
      `CHK("run_kept", 1'b1, CLK_RUN)
      wr(SCLKG_DIV_OFS, 32'hff);
      rdc("div_max", SCLKG_DIV_OFS, 32'hff);
      wr(SCLKG_DIV_OFS, 32'h0);
      $display("test divider done");
      wr(SCLKG_TRIM_OFS, 32'h45);
      cnt();
      `CHK("out_oe", 1'b1, CRYSTAL_OUT_PIN_OE)
      `CHK("out_rate", 1'b1, (no inside {[np-1:np+1]}))
      @(posedge CORE_CLK);
      RTC_ON_XTAL <= 1'b1;
      repeat (3) @(negedge CORE_CLK);
      `CHK("out_rtc", 1'b0, CRYSTAL_OUT_PIN_OE)
      @(posedge CORE_CLK);
      RTC_ON_XTAL <= 1'b0;
      wr(SCLKG_TRIM_OFS, 32'h05);
      `CHK("out_off", 1'b0, CRYSTAL_OUT_PIN_OE)
      @(posedge CORE_CLK);
      PORT_OUT_EN <= 1'b1;
      repeat (2) @(negedge CORE_CLK);
      `CHK("pin_hi", 2'b11, {CRYSTAL_OUT_PIN_OE, CRYSTAL_OUT_PIN_O})
      @(posedge CORE_CLK);
      PORT_OUT_VAL <= 1'b0;
      repeat (2) @(negedge CORE_CLK);
      `CHK("pin_lo", 2'b10, {CRYSTAL_OUT_PIN_OE, CRYSTAL_OUT_PIN_O})
      @(posedge CORE_CLK);
      RTC_ON_XTAL <= 1'b1;
      repeat (2) @(negedge CORE_CLK);
      `CHK("pin_rtc", 1'b0, CRYSTAL_OUT_PIN_OE)
      @(posedge CORE_CLK);
      RTC_ON_XTAL <= 1'b0;
      PORT_OUT_EN <= 1'b0;
      PORT_OUT_VAL <= 1'b1;
      $display("test clock out done");
      wr(SCLKG_AUX_OFS, 32'h80);
      rdc("lp_set", SCLKG_AUX_OFS, 32'h80);
      rst(1'b0);
      rdc("trim_kept", SCLKG_TRIM_OFS, 32'h05);
      rdc("lp_clr", SCLKG_AUX_OFS, 32'h0);
      rst(1'b1);
      rdc("trim_por", SCLKG_TRIM_OFS, 32'(SCLKG_TRIM_FACTORY));
      $display("test resets done");
      wait_run();
      wr(SCLKG_CTRL_OFS, 32'h1);
      cnt();
      `CHK("pd_run", 1'b0, CLK_RUN)
      `CHK("pd_cpu", 0, nc)
      `CHK("pd_clk", 1'b0, CPU_CORE_CLK)
      wr(SCLKG_CTRL_OFS, 32'h0);
      wait_run();
      `CHK("rewake", 1'b1, (c >= 2 * SCLKG_WAKE_OTHER - 16))
      $display("test power down done");
      tally_and_finish();
   end
endmodule
